// [dwcu_pkg.sv]
// Package of constants for the wiper command unit
package dwcu_pkg;
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 16;
  localparam int WIPER_BITS = 10;
  localparam int NV_WORDS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] FRAME_LAST = 5'h17;
  // Instruction numbers, top nibble of a frame
  localparam logic [3:0] INS_NOP = 4'h0;
  localparam logic [3:0] INS_RECALL_ONE = 4'h1;
  localparam logic [3:0] INS_SAVE = 4'h2;
  localparam logic [3:0] INS_STORE_USER = 4'h3;
  localparam logic [3:0] INS_RECALL_ALL = 4'h8;
  localparam logic [3:0] INS_RESTORE_USER = 4'h9;
  localparam logic [3:0] INS_READ_WIPER = 4'ha;
  localparam logic [3:0] INS_LOAD = 4'hb;
  localparam logic [3:0] INS_SHIFT_LEFT = 4'hc;
  localparam logic [3:0] INS_INCREMENT = 4'he;
  // Nonvolatile map
  localparam logic [3:0] NV_ADDR_WIPER = 4'h0;
  localparam logic [3:0] NV_ADDR_OUTS = 4'h1;
  localparam logic [DATA_BITS-1:0] NV_RESET_VAL = 16'h0000;
  localparam logic [WIPER_BITS-1:0] WIPER_FULL = 10'h3ff;
  localparam logic [WIPER_BITS-1:0] WIPER_MID = 10'h200;
  localparam logic [WIPER_BITS-1:0] WIPER_ONE = 10'h001;
  localparam logic [WIPER_BITS-1:0] WIPER_ZERO = 10'h000;
  // Idle pin levels: sclk low, selects and strobes high
  localparam logic [4:0] PINS_IDLE = 5'h0f;
endpackage

// [dwcu_sync.sv]
// Two-flop synchroniser for pin inputs
module dwcu_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// [dwcu_wiper_decode.sv]
// One-hot decoder from wiper code to tap select
module dwcu_wiper_decode #(
  parameter int WIDTH = 10
) (
  // Code in
  input wire logic [WIDTH-1:0] i_code,
  // Tap select out
  output logic [(1<<WIDTH)-1:0] o_tap
);
  always_comb
  begin
    o_tap = '0;
    o_tap[i_code] = 1'b1;
  end
endmodule

// [dwcu_core.sv]
// Serial command interpreter for a 10-bit digital potentiometer
// Operation
// - The 10-bit wiper code selects exactly one of 1024 taps.
// - Code zero is the B end; each increment moves one tap up.
// - Command B0 loads the low 10 data bits into the wiper.
// - Command E0 adds one to the wiper, holding at full, data ignored.
// - Command 20 saves the wiper into nonvolatile location zero.
// - Write-protect low blocks every nonvolatile write.
// - Command 10 loads the wiper from nonvolatile location zero.
// - Power-on and recall pin strobe restore the wiper from location zero.
// - After command 10 (recall-one) the device stays in read power until a no-op.
// - Saved latched outputs restore at power-on and on recall-all or recall-one.
// - User 16-bit words store via instruction 3, restore via 9.
// - Command C0 doubles the wiper by a left shift.
// - Left shift turns zero into one and midscale or above into full.
// - Each frame shifts out the previous 24-bit word, updated by reads.
module dwcu_core #(
  parameter int WIPER_BITS = dwcu_pkg::WIPER_BITS,
  parameter int NV_WORDS = dwcu_pkg::NV_WORDS
) (
  // Clock and reset (reset stands for power-on)
  input wire logic i_mclk,
  input wire logic i_srst,
  // Serial link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  // Control pins
  input wire logic i_preset_recall_pin_n,
  input wire logic i_wp_n,
  // Wiper and outputs
  output logic [WIPER_BITS-1:0] o_wiper_setting_register,
  output logic [(1<<WIPER_BITS)-1:0] o_wiper_tap,
  output logic o_latched_output_one,
  output logic o_latched_output_two,
  output logic o_read_power_mode
);
  localparam int FB = dwcu_pkg::FRAME_BITS;
  localparam int DB = dwcu_pkg::DATA_BITS;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pins_sync;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic pr_n_s;
  logic wp_n_s;

  // Resets to idle levels so no false edge follows reset
  dwcu_sync #(.WIDTH(5), .RESET_VAL(dwcu_pkg::PINS_IDLE)) u_sync (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_async({i_sclk, i_cs_n, i_serial_in_pin, i_preset_recall_pin_n, i_wp_n}),
    .o_sync(pins_sync)
  );
  assign {sclk_s, cs_n_s, sdi_s, pr_n_s, wp_n_s} = pins_sync;

  // ---------------------------------------------------------------
  // Edge detection on synchronised pins
  // ---------------------------------------------------------------
  logic sclk_d_reg;
  logic cs_n_d_reg;
  logic pr_n_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_end;
  logic pr_rise;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sclk_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
      pr_n_d_reg <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
      pr_n_d_reg <= pr_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_reg & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_reg & ~cs_n_s;
  assign frame_end = cs_n_s & ~cs_n_d_reg;
  // Strobe acts on release so a held pin recalls once
  assign pr_rise = pr_n_s & ~pr_n_d_reg;

  // ---------------------------------------------------------------
  // Shift registers
  // ---------------------------------------------------------------
  logic [FB-1:0] rx_reg;
  logic [FB-1:0] tx_reg;
  logic [FB-1:0] prev_word_reg;
  logic [dwcu_pkg::CNT_BITS-1:0] bit_cnt_reg;
  logic frame_ok;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst || frame_end || (cs_n_s && !cs_n_d_reg))
      bit_cnt_reg <= '0;
    else if (sclk_rise && bit_cnt_reg <= dwcu_pkg::FRAME_LAST + 5'h01)
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
  end

  // Short or long frames are dropped, not half-executed
  assign frame_ok = frame_end && (bit_cnt_reg == dwcu_pkg::FRAME_LAST + 5'h01);

  // Sample on rising edge, MSB first
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      rx_reg <= '0;
    else if (sclk_rise)
      rx_reg <= {rx_reg[FB-2:0], sdi_s};
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [3:0] ins;
  logic [3:0] addr;
  logic [DB-1:0] data;
  assign ins = rx_reg[FB-1:FB-4];
  assign addr = rx_reg[FB-5:FB-8];
  assign data = rx_reg[DB-1:0];

  // ---------------------------------------------------------------
  // Nonvolatile store
  // ---------------------------------------------------------------
  logic [DB-1:0] nv_store_reg [NV_WORDS];
  logic nv_we;
  logic [3:0] nv_waddr;
  logic [DB-1:0] nv_wdata;

  always_comb
  begin
    nv_we = 1'b0;
    nv_waddr = dwcu_pkg::NV_ADDR_WIPER;
    nv_wdata = '0;
    if (frame_ok)
    begin
      unique case (ins)
        dwcu_pkg::INS_SAVE:
        begin
          nv_we = 1'b1;
          nv_wdata = DB'(o_wiper_setting_register);
        end
        dwcu_pkg::INS_STORE_USER:
        begin
          nv_we = 1'b1;
          nv_waddr = addr;
          nv_wdata = data;
        end
        default:
        begin
          nv_we = 1'b0;
        end
      endcase
    end
  end

  // Reset clears it; models a blank part
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < NV_WORDS; i++)
        nv_store_reg[i] <= dwcu_pkg::NV_RESET_VAL;
    end
    else if (nv_we && wp_n_s)
      nv_store_reg[nv_waddr] <= nv_wdata;
  end

  // ---------------------------------------------------------------
  // Wiper arithmetic
  // ---------------------------------------------------------------
  function automatic logic [WIPER_BITS-1:0] wiper_double(input logic [WIPER_BITS-1:0] w);
    logic [WIPER_BITS-1:0] r;
    r = {w[WIPER_BITS-2:0], 1'b0};
    // Zero to one, midscale up to full
    if (w == dwcu_pkg::WIPER_ZERO)
      r = dwcu_pkg::WIPER_ONE;
    else if (w >= dwcu_pkg::WIPER_MID)
      r = dwcu_pkg::WIPER_FULL;
    return r;
  endfunction

  function automatic logic [WIPER_BITS-1:0] wiper_inc(input logic [WIPER_BITS-1:0] w);
    return (w == dwcu_pkg::WIPER_FULL) ? w : w + WIPER_BITS'(1);
  endfunction

  logic [WIPER_BITS-1:0] nv_wiper;
  logic [1:0] nv_outs;
  assign nv_wiper = nv_store_reg[dwcu_pkg::NV_ADDR_WIPER][WIPER_BITS-1:0];
  assign nv_outs = nv_store_reg[dwcu_pkg::NV_ADDR_OUTS][1:0];

  // ---------------------------------------------------------------
  // Wiper setting register
  // ---------------------------------------------------------------
  logic [WIPER_BITS-1:0] wiper_reg;
  logic restore_pending_reg;

  // Power-on restore waits one cycle for the store to settle
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      restore_pending_reg <= 1'b1;
    else
      restore_pending_reg <= 1'b0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      wiper_reg <= dwcu_pkg::WIPER_ZERO;
    else if (restore_pending_reg || pr_rise)
      wiper_reg <= nv_wiper;
    else if (frame_ok)
    begin
      unique case (ins)
        dwcu_pkg::INS_LOAD: wiper_reg <= data[WIPER_BITS-1:0];
        dwcu_pkg::INS_INCREMENT: wiper_reg <= wiper_inc(wiper_reg);
        dwcu_pkg::INS_SHIFT_LEFT: wiper_reg <= wiper_double(wiper_reg);
        dwcu_pkg::INS_RECALL_ONE, dwcu_pkg::INS_RECALL_ALL: wiper_reg <= nv_wiper;
        default: wiper_reg <= wiper_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Latched outputs and power state
  // ---------------------------------------------------------------
  logic [1:0] outs_reg;
  logic read_mode_reg;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      outs_reg <= 2'h0;
    else if (restore_pending_reg ||
             (frame_ok && (ins == dwcu_pkg::INS_RECALL_ONE || ins == dwcu_pkg::INS_RECALL_ALL)))
      outs_reg <= nv_outs;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      read_mode_reg <= 1'b0;
    else if (frame_ok && ins == dwcu_pkg::INS_RECALL_ONE)
      read_mode_reg <= 1'b1;
    else if (frame_ok && ins == dwcu_pkg::INS_NOP)
      read_mode_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Read-back word
  // ---------------------------------------------------------------
  // Previous word, with read data spliced in
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      prev_word_reg <= '0;
    else if (frame_ok)
    begin
      unique case (ins)
        dwcu_pkg::INS_RESTORE_USER: prev_word_reg <= {ins, addr, nv_store_reg[addr]};
        dwcu_pkg::INS_READ_WIPER: prev_word_reg <= {ins, addr, DB'(wiper_reg)};
        default: prev_word_reg <= rx_reg;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      tx_reg <= '0;
    else if (cs_n_d_reg && !cs_n_s)
      tx_reg <= prev_word_reg;
    else if (sclk_fall)
      tx_reg <= {tx_reg[FB-2:0], 1'b0};
  end

  dwcu_wiper_decode #(.WIDTH(WIPER_BITS)) u_decode (
    .i_code(wiper_reg),
    .o_tap(o_wiper_tap)
  );

  assign o_serial_out_pin = tx_reg[FB-1];
  assign o_wiper_setting_register = wiper_reg;
  assign o_latched_output_one = outs_reg[0];
  assign o_latched_output_two = outs_reg[1];
  assign o_read_power_mode = read_mode_reg;
endmodule

// [dwcu_core_properties.sv]
// Port timing checker for the wiper command unit
module dwcu_chk #(
  parameter int WIPER_BITS = 10
) (
  // Clock and pins
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_preset_recall_pin_n,
  // Outputs
  input wire logic o_serial_out_pin,
  input wire logic [WIPER_BITS-1:0] o_wiper_setting_register,
  input wire logic [(1<<WIPER_BITS)-1:0] o_wiper_tap,
  input wire logic o_latched_output_one,
  input wire logic o_latched_output_two,
  input wire logic o_read_power_mode
);
  logic [3:0] cmd_age_reg;
  logic [3:0] pr_age_reg;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  // ------
  // Ages of frame end and recall release
  // ------
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      cmd_age_reg <= 4'hf;
    else if ($rose(i_cs_n))
      cmd_age_reg <= 4'h0;
    else if (cmd_age_reg != 4'hf)
      cmd_age_reg <= cmd_age_reg + 4'h1;
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      pr_age_reg <= 4'hf;
    else if ($rose(i_preset_recall_pin_n))
      pr_age_reg <= 4'h0;
    else if (pr_age_reg != 4'hf)
      pr_age_reg <= pr_age_reg + 4'h1;
  end
  // Pins pass two sync stages, so effects lag a few cycles
  sequence s_cmd;
    cmd_age_reg inside {[4'h2:4'h7]};
  endsequence
  sequence s_pr;
    pr_age_reg inside {[4'h2:4'h7]};
  endsequence
  chk_tap_one_hot: assert property ($onehot(o_wiper_tap) && o_wiper_tap[o_wiper_setting_register])
    else $error("tap select wrong");
  chk_tap_follow: assert property ($changed(o_wiper_tap) |-> $changed(o_wiper_setting_register))
    else $error("tap moved alone");
  chk_wiper_cause: assert property ($changed(o_wiper_setting_register) |-> s_cmd or s_pr)
    else $error("wiper moved without cause");
  chk_mode_cause: assert property ($changed(o_read_power_mode) |-> s_cmd)
    else $error("read mode moved without frame");
  chk_outs_cause: assert property ($changed({o_latched_output_one, o_latched_output_two}) |-> s_cmd)
    else $error("latched outputs moved without frame");
  chk_frame_quiet: assert property ((!i_cs_n && i_preset_recall_pin_n)[*8]
    |-> $stable({o_wiper_setting_register, o_read_power_mode}))
    else $error("state moved inside a frame");
  chk_sdo_hold: assert property ((i_sclk && !i_cs_n)[*4] |-> $stable(o_serial_out_pin))
    else $error("serial out moved while clock high");
  chk_sdo_idle: assert property ((i_cs_n)[*4] |-> $stable(o_serial_out_pin))
    else $error("serial out moved outside frame");
endmodule

bind dwcu_core dwcu_chk #(.WIPER_BITS(WIPER_BITS)) u_chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_sclk(i_sclk),
  .i_cs_n(i_cs_n), .i_preset_recall_pin_n(i_preset_recall_pin_n), .o_serial_out_pin(o_serial_out_pin),
  .o_wiper_setting_register(o_wiper_setting_register), .o_wiper_tap(o_wiper_tap),
  .o_latched_output_one(o_latched_output_one), .o_latched_output_two(o_latched_output_two),
  .o_read_power_mode(o_read_power_mode));

// [dwcu_host_model.sv]
// Host model driving the serial command link
module dwcu_host_model (
  // Link pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] rx_word;
  event done;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b1;
  end
  // ------
  // Frame transfer
  // ------
  // MSB first frame
  task automatic frame(input logic [23:0] w, input int nbits);
    int i;
    // Odd offset keeps the link out of phase with the system clock
    #13 o_cs_n = 1'b0;
    #320;
    for (i = 23; i > 23 - nbits; i--)
    begin
      o_sdi = w[i];
      #160 o_sclk = 1'b1;
      #150 rx_word = {rx_word[22:0], i_sdo};
      #10 o_sclk = 1'b0;
    end
    #160 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #480 -> done;
  endtask
endmodule

// [test_digipot_wiper_command_unit.sv]
// Self-checking bench for the wiper command unit
module test_digipot_wiper_command_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_srst, i_preset_recall_pin_n, i_wp_n, sclk, cs_n, serial_in_pin, serial_out_pin, o1, o2, mode;
  logic [9:0] wiper;
  logic [1023:0] tap;
  logic [9:0] wip;
  logic [1:0] outs;
  logic emode;
  logic [15:0] nv [16];
  logic [23:0] prev;
  logic [37:0] note;
  logic [37:0] seen;
  logic [37:0] exq [$];
  bit started;
  int bad_count, samples_checked;
  // Each recall-one here is followed by a no-op
  logic [23:0] tbl [26] = '{24'h20aaaa, 24'hb003ff, 24'he00000, 24'hb00000, 24'hc00000, 24'hc00000,
    24'hb00200, 24'hc00000, 24'hb00155, 24'hc00000, 24'h10ffff, 24'h000000, 24'h310001, 24'h32aaaa,
    24'h800000, 24'h920000, 24'h000000, 24'ha00000, 24'h000000, 24'h70abcd, 24'h310002, 24'hb00055,
    24'h200000, 24'h31ffff, 24'h100000, 24'h000000};
  dwcu_core u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in_pin(serial_in_pin),
    .o_serial_out_pin(serial_out_pin), .i_preset_recall_pin_n(i_preset_recall_pin_n), .i_wp_n(i_wp_n),
    .o_wiper_setting_register(wiper), .o_wiper_tap(tap), .o_latched_output_one(o1),
    .o_latched_output_two(o2), .o_read_power_mode(mode));
  dwcu_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(serial_in_pin), .i_sdo(serial_out_pin));
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [37:0] s, input logic [37:0] e);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic op(input logic [23:0] w, input int n);
    logic [23:0] echo;
    echo = prev;
    if (n == 24)
    begin
      prev = w;
      case (w[23:20])
        4'h0: emode = 1'b0;
        4'h1: {wip, outs, emode} = {nv[0][9:0], nv[1][1:0], 1'b1};
        4'h2: if (i_wp_n) nv[0] = {6'h00, wip};
        4'h3: if (i_wp_n) nv[w[19:16]] = w[15:0];
        4'h8: {wip, outs} = {nv[0][9:0], nv[1][1:0]};
        4'h9: prev = {w[23:16], nv[w[19:16]]};
        4'ha: prev = {w[23:16], 6'h00, wip};
        4'hb: wip = w[9:0];
        4'hc: wip = (wip == 10'h000) ? 10'h001 : (wip >= 10'h200) ? 10'h3ff : wip << 1;
        4'he: wip = (wip == 10'h3ff) ? wip : wip + 10'h001;
        default: ;
      endcase
    end
    exq.push_back({started && n == 24, echo, wip, emode, outs});
    started = 1'b1;
    // Start on a clock edge so link edges never meet one
    @(posedge i_mclk);
    u_host.frame(w, n);
  endtask
  always @(u_host.done)
  begin
    note = exq.pop_front();
    seen = {note[37], note[37] ? u_host.rx_word : note[36:13], wiper, mode, o2, o1};
    check("frame result", seen, note);
    check("wiper tap", {37'h0, tap === (1024'h1 << note[12:3])}, 38'h1);
  end
  // ------
  // Main sequence
  // ------
  initial
  begin
    i_srst = 1'b1;
    i_preset_recall_pin_n = 1'b1;
    i_wp_n = 1'b1;
    {wip, outs, emode, prev} = '0;
    foreach (nv[k]) nv[k] = dwcu_pkg::NV_RESET_VAL;
    void'($urandom(36803));
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    op(24'h000000, 24);
    op(24'hb00100, 24);
    repeat (2) op({8'he0, 16'($urandom)}, 24);
    for (int k = 0; k < 26; k++)
    begin
      // Protection goes on before the refused writes
      if (k == 21) @(posedge i_mclk) i_wp_n <= 1'b0;
      if (k == 25) @(posedge i_mclk) i_wp_n <= 1'b1;
      op(tbl[k], 24);
    end
    // Short frame must be dropped and not echoed
    op(24'hb003ff, 20);
    op(24'h000000, 24);
    repeat (4) op({8'hb0, 16'($urandom)}, 24);
    @(posedge i_mclk) i_preset_recall_pin_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_preset_recall_pin_n <= 1'b1;
    wip = nv[0][9:0];
    exq.push_back({1'b0, 24'h000000, wip, emode, outs});
    repeat (12) @(posedge i_mclk);
    -> u_host.done;
    repeat (2) @(posedge i_mclk);
    print_verdict();
  end
  initial
  begin
    #2000000;
    bad_count++;
    print_verdict();
  end
endmodule
